// >>> common/pwm_clk_pkg.sv
// Purpose: Shared constants for the PWM clock and synchronous update block
// Assumes: AXI4-Lite, 32-bit data, 8-bit byte address
// Notes:   Offsets are byte addresses of aligned words
package pwm_clk_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int STRB_W = 4;
   localparam int VAL_W  = 16;
   localparam int SYNC_W = 4;

   // Register offsets
   localparam logic [7:0] ADDR_CLK_CFG         = 8'h00;
   localparam logic [7:0] ADDR_PROTECT         = 8'h04;
   localparam logic [7:0] ADDR_SYNC_MODE       = 8'h08;
   localparam logic [7:0] ADDR_DUTY_SHADOW     = 8'h0c;
   localparam logic [7:0] ADDR_PERIOD_SHADOW   = 8'h10;
   localparam logic [7:0] ADDR_DEADTIME_SHADOW = 8'h14;
   localparam logic [7:0] ADDR_SYNC_SHADOW     = 8'h18;
   localparam logic [7:0] ADDR_DUTY_ACTIVE     = 8'h1c;
   localparam logic [7:0] ADDR_PERIOD_ACTIVE   = 8'h20;
   localparam logic [7:0] ADDR_DEADTIME_ACTIVE = 8'h24;
   localparam logic [7:0] ADDR_SYNC_ACTIVE     = 8'h28;
   localparam logic [7:0] ADDR_STATUS          = 8'h2c;
   localparam int         ADDR_STEP            = 4;

   // Shadow entry indices
   localparam int SH_DUTY     = 0;
   localparam int SH_PERIOD   = 1;
   localparam int SH_DEADTIME = 2;
   localparam int SH_SYNC     = 3;
   localparam int SH_COUNT    = 4;

   // Clock configuration fields
   localparam int DIVIDE_FACTOR_A_LSB = 0;
   localparam int PRESCALE_SELECT_A_LSB = 8;
   localparam int DIVIDE_FACTOR_B_LSB = 16;
   localparam int PRESCALE_SELECT_B_LSB = 24;
   localparam int DIV_W    = 8;
   localparam int PRE_W    = 4;
   localparam logic [31:0] CLK_CFG_MASK  = 32'h0fff_0fff;
   localparam logic [31:0] CLK_CFG_RESET = 32'h0000_0000;

   // Protection, mode and status fields
   localparam int SOFT_PROT_BIT  = 0;
   localparam int HARD_PROT_BIT  = 1;
   localparam int SYNC_PRES_BIT  = 0;
   localparam int UPDATE_METHOD_SELECT_LSB       = 4;
   localparam int UPDATE_METHOD_SELECT_W         = 2;
   localparam int STAT_CNT_LSB   = 8;

   // Prescaler
   localparam int         PRESCALE_W   = 10;
   localparam logic [3:0] PRESCALE_MAX = 4'ha;

   localparam logic [15:0] VAL_RESET    = 16'h0000;
   localparam logic [1:0]  RESP_OKAY    = 2'b00;
   localparam logic [1:0]  RESP_SLVERR  = 2'b10;
endpackage

// >>> core/pwm_clock_divider.sv
// Purpose: Power-of-two prescaler followed by an 8-bit divider
// Assumes: One clock, synchronous active-low reset
// Notes:   Output is a one-cycle tick per divided clock period
`timescale 1ns/100ps
`default_nettype none
module pwm_clock_divider (
   // Clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       ce,
   // Configuration
   input  wire logic [3:0] prescale_select,
   input  wire logic [7:0] divide_factor,
   // Divided clock tick
   output logic            tick_out
);
   logic [pwm_clk_pkg::PRESCALE_W-1:0] pre_cnt;
   logic [pwm_clk_pkg::PRESCALE_W-1:0] pre_mask;
   logic                               pre_tick;
   logic [7:0]                         div_cnt;
   logic                               div_last;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pre_cnt <= '0;
      end else if (ce) begin
         pre_cnt <= pre_cnt + 1'b1;
      end
   end

   // Reserved select codes give no tick at all
   always_comb begin
      pre_mask = pwm_clk_pkg::PRESCALE_W'((11'h001 << prescale_select) - 11'h001);
      pre_tick = (prescale_select <= pwm_clk_pkg::PRESCALE_MAX) &&
                 ((pre_cnt & pre_mask) == pre_mask);
   end

   assign div_last = (div_cnt >= divide_factor - 8'h01);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_cnt <= '0;
      end else if (ce && pre_tick) begin
         if (divide_factor <= 8'h01 || div_last) begin
            div_cnt <= '0;
         end else begin
            div_cnt <= div_cnt + 8'h01;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_out <= 1'b0;
      end else if (ce) begin
         // Factor 0 stops, 1 passes, 2..255 divides
         tick_out <= pre_tick && (divide_factor == 8'h01 ||
                     (divide_factor >= 8'h02 && div_last));
      end
   end

   a_clock_stopped: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && divide_factor == 8'h00 |=> !tick_out)
      else $error("divided clock ticked with factor zero");

   a_clock_passed: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && divide_factor == 8'h01 |=> tick_out == $past(pre_tick))
      else $error("factor one did not pass the prescaler tick");

   a_prescale_full: assert property (@(posedge aclk) disable iff (!aresetn)
      prescale_select == 4'h0 |-> pre_tick)
      else $error("select zero must tick every cycle");

   a_prescale_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
      prescale_select > pwm_clk_pkg::PRESCALE_MAX |-> !pre_tick)
      else $error("reserved select produced a tick");
endmodule
`default_nettype wire

// >>> core/pwm_shadow_reg.sv
// Purpose: Double-buffered value with pending flag
// Assumes: Update strobe comes from the same clock
// Notes:   A write in the update cycle stays pending for the next one
`timescale 1ns/100ps
`default_nettype none
module pwm_shadow_reg (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   // Software side
   input  wire logic        wr_en,
   input  wire logic [15:0] wr_data,
   // Update event
   input  wire logic        update,
   // State
   output logic [15:0]      shadow,
   output logic [15:0]      active,
   output logic             pending
);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shadow <= pwm_clk_pkg::VAL_RESET;
      end else if (ce && wr_en) begin
         shadow <= wr_data;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pending <= 1'b0;
      end else if (ce) begin
         if (wr_en) begin
            pending <= 1'b1;
         end else if (update) begin
            pending <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         active <= pwm_clk_pkg::VAL_RESET;
      end else if (ce && update && pending) begin
         active <= shadow;
      end
   end

   a_shadow_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      !(ce && update && pending) |=> $stable(active))
      else $error("active value changed without an update");

   a_shadow_last: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && update && pending |=> active == $past(shadow))
      else $error("update did not apply the last written value");
endmodule
`default_nettype wire

// >>> core/pwm_clock_sync.sv
// Purpose: PWM clock generator and synchronous update, AXI4-Lite registers
// Assumes: 125 MHz aclk, synchronous active-low reset, ce freezes all state
// Notes:   One channel's counter stands in for the PWM period timing
`timescale 1ns/100ps
`default_nettype none
module pwm_clock_sync (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   // Hardware protect flag
   input  wire logic        hard_protect_flag_g0,
   // AXI4-Lite write address
   input  wire logic [7:0]  awaddr,
   input  wire logic [2:0]  awprot,
   input  wire logic        awvalid,
   output logic             awready,
   // AXI4-Lite write data
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   // AXI4-Lite write response
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // AXI4-Lite read address
   input  wire logic [7:0]  araddr,
   input  wire logic [2:0]  arprot,
   input  wire logic        arvalid,
   output logic             arready,
   // AXI4-Lite read data
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // Block outputs
   output logic             divided_clock_a,
   output logic             divided_clock_b,
   output logic             update_pulse,
   output logic             pwm_out
);
   localparam int N = pwm_clk_pkg::SH_COUNT;

   logic [31:0]                     clk_cfg;
   logic                            soft_protect_flag_g0;
   logic                            sync_channels_present;
   logic [pwm_clk_pkg::UPDATE_METHOD_SELECT_W-1:0]  update_method_select;
   logic                            tick_a;
   logic                            tick_b;
   logic [15:0]                     period_count;
   logic                            period_end;
   logic [pwm_clk_pkg::SYNC_W-1:0]  sync_update_counter;
   logic [pwm_clk_pkg::SYNC_W-1:0]  sync_update_period_value;
   logic                            sync_reached;
   logic                            update_event;
   logic                            write_fire;
   logic                            read_fire;
   logic                            wr_hit;
   logic                            cfg_open;
   logic [31:0]                     next_rdata;
   logic                            next_rmapped;
   logic [N-1:0]                    wr_en;
   logic [N-1:0]                    pending;
   logic [15:0]                     shadow_val [N];
   logic [15:0]                     active_val [N];
   logic [15:0]                     wr_val;
   logic [31:0]                     wr_word;

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < pwm_clk_pkg::STRB_W; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite handshakes

   assign write_fire = awvalid && awready && wvalid && wready;
   assign read_fire  = arvalid && arready;

   // Both address and data are taken on the same edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         wready  <= 1'b0;
         bvalid  <= 1'b0;
         bresp   <= pwm_clk_pkg::RESP_OKAY;
      end else if (ce) begin
         awready <= !awready && awvalid && wvalid && !bvalid;
         wready  <= !awready && awvalid && wvalid && !bvalid;
         if (write_fire) begin
            bvalid <= 1'b1;
            bresp  <= wr_hit ? pwm_clk_pkg::RESP_OKAY
                             : pwm_clk_pkg::RESP_SLVERR;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= '0;
         rresp   <= pwm_clk_pkg::RESP_OKAY;
      end else if (ce) begin
         arready <= !arready && arvalid && !rvalid;
         if (read_fire) begin
            rvalid <= 1'b1;
            rdata  <= next_rdata;
            rresp  <= next_rmapped ? pwm_clk_pkg::RESP_OKAY
                                   : pwm_clk_pkg::RESP_SLVERR;
         end else if (rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register writes

   always_comb begin
      case (awaddr)
         pwm_clk_pkg::ADDR_CLK_CFG,
         pwm_clk_pkg::ADDR_PROTECT,
         pwm_clk_pkg::ADDR_SYNC_MODE,
         pwm_clk_pkg::ADDR_DUTY_SHADOW,
         pwm_clk_pkg::ADDR_PERIOD_SHADOW,
         pwm_clk_pkg::ADDR_DEADTIME_SHADOW,
         pwm_clk_pkg::ADDR_SYNC_SHADOW,
         pwm_clk_pkg::ADDR_DUTY_ACTIVE,
         pwm_clk_pkg::ADDR_PERIOD_ACTIVE,
         pwm_clk_pkg::ADDR_DEADTIME_ACTIVE,
         pwm_clk_pkg::ADDR_SYNC_ACTIVE,
         pwm_clk_pkg::ADDR_STATUS: wr_hit = 1'b1;
         default:                  wr_hit = 1'b0;
      endcase
   end

   assign cfg_open = !soft_protect_flag_g0 && !hard_protect_flag_g0;
   assign wr_word  = merge(32'h0, wdata, wstrb);
   assign wr_val   = wr_word[pwm_clk_pkg::VAL_W-1:0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clk_cfg <= pwm_clk_pkg::CLK_CFG_RESET;
      end else if (ce && write_fire && cfg_open &&
                   awaddr == pwm_clk_pkg::ADDR_CLK_CFG) begin
         clk_cfg <= merge(clk_cfg, wdata, wstrb) & pwm_clk_pkg::CLK_CFG_MASK;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         soft_protect_flag_g0  <= 1'b0;
         sync_channels_present <= 1'b0;
         update_method_select  <= '0;
      end else if (ce && write_fire && wstrb[0]) begin
         if (awaddr == pwm_clk_pkg::ADDR_PROTECT) begin
            soft_protect_flag_g0 <= wdata[pwm_clk_pkg::SOFT_PROT_BIT];
         end
         if (awaddr == pwm_clk_pkg::ADDR_SYNC_MODE) begin
            sync_channels_present <= wdata[pwm_clk_pkg::SYNC_PRES_BIT];
            update_method_select  <=
               wdata[pwm_clk_pkg::UPDATE_METHOD_SELECT_LSB +: pwm_clk_pkg::UPDATE_METHOD_SELECT_W];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Divided clocks

   pwm_clock_divider u_div_a (
      .aclk            (aclk),
      .aresetn         (aresetn),
      .ce              (ce),
      .prescale_select (clk_cfg[pwm_clk_pkg::PRESCALE_SELECT_A_LSB +: pwm_clk_pkg::PRE_W]),
      .divide_factor   (clk_cfg[pwm_clk_pkg::DIVIDE_FACTOR_A_LSB +: pwm_clk_pkg::DIV_W]),
      .tick_out        (tick_a)
   );

   pwm_clock_divider u_div_b (
      .aclk            (aclk),
      .aresetn         (aresetn),
      .ce              (ce),
      .prescale_select (clk_cfg[pwm_clk_pkg::PRESCALE_SELECT_B_LSB +: pwm_clk_pkg::PRE_W]),
      .divide_factor   (clk_cfg[pwm_clk_pkg::DIVIDE_FACTOR_B_LSB +: pwm_clk_pkg::DIV_W]),
      .tick_out        (tick_b)
   );

   ////////////////////////////////////////////////////////////////////////////
   // PWM period and synchronous update period

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         period_count <= '0;
         period_end   <= 1'b0;
      end else if (ce) begin
         period_end <= 1'b0;
         if (tick_a) begin
            if (period_count >= active_val[pwm_clk_pkg::SH_PERIOD]) begin
               period_count <= '0;
               period_end   <= 1'b1;
            end else begin
               period_count <= period_count + 16'h0001;
            end
         end
      end
   end

   assign sync_update_period_value =
      active_val[pwm_clk_pkg::SH_SYNC][pwm_clk_pkg::SYNC_W-1:0];
   assign sync_reached = (sync_update_counter == sync_update_period_value);
   assign update_event = period_end && sync_reached;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync_update_counter <= '0;
      end else if (ce && period_end) begin
         sync_update_counter <= sync_reached ? '0
                                : sync_update_counter + 1'b1;
      end
   end

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_shadow
         assign wr_en[g] = write_fire && awaddr ==
            8'(pwm_clk_pkg::ADDR_DUTY_SHADOW + g * pwm_clk_pkg::ADDR_STEP);
         pwm_shadow_reg u_shadow (
            .aclk    (aclk),
            .aresetn (aresetn),
            .ce      (ce),
            .wr_en   (wr_en[g]),
            .wr_data (g == pwm_clk_pkg::SH_SYNC ?
                      {12'h000, wr_val[pwm_clk_pkg::SYNC_W-1:0]} : wr_val),
            .update  (update_event),
            .shadow  (shadow_val[g]),
            .active  (active_val[g]),
            .pending (pending[g])
         );
      end
   endgenerate

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         divided_clock_a <= 1'b0;
         divided_clock_b <= 1'b0;
         update_pulse    <= 1'b0;
         pwm_out         <= 1'b0;
      end else if (ce) begin
         divided_clock_a <= tick_a;
         divided_clock_b <= tick_b;
         update_pulse    <= update_event;
         pwm_out         <= period_count < active_val[pwm_clk_pkg::SH_DUTY];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register reads

   always_comb begin
      next_rdata   = 32'h0000_0000;
      next_rmapped = 1'b1;
      case (araddr)
         pwm_clk_pkg::ADDR_CLK_CFG:         next_rdata = clk_cfg;
         pwm_clk_pkg::ADDR_PROTECT:         next_rdata = {30'h0,
            hard_protect_flag_g0, soft_protect_flag_g0};
         pwm_clk_pkg::ADDR_SYNC_MODE:       next_rdata = {26'h0,
            update_method_select, 3'h0, sync_channels_present};
         pwm_clk_pkg::ADDR_DUTY_SHADOW:     next_rdata = {16'h0,
            shadow_val[pwm_clk_pkg::SH_DUTY]};
         pwm_clk_pkg::ADDR_PERIOD_SHADOW:   next_rdata = {16'h0,
            shadow_val[pwm_clk_pkg::SH_PERIOD]};
         pwm_clk_pkg::ADDR_DEADTIME_SHADOW: next_rdata = {16'h0,
            shadow_val[pwm_clk_pkg::SH_DEADTIME]};
         pwm_clk_pkg::ADDR_SYNC_SHADOW:     next_rdata = {16'h0,
            shadow_val[pwm_clk_pkg::SH_SYNC]};
         pwm_clk_pkg::ADDR_DUTY_ACTIVE:     next_rdata = {16'h0,
            active_val[pwm_clk_pkg::SH_DUTY]};
         pwm_clk_pkg::ADDR_PERIOD_ACTIVE:   next_rdata = {16'h0,
            active_val[pwm_clk_pkg::SH_PERIOD]};
         pwm_clk_pkg::ADDR_DEADTIME_ACTIVE: next_rdata = {16'h0,
            active_val[pwm_clk_pkg::SH_DEADTIME]};
         pwm_clk_pkg::ADDR_SYNC_ACTIVE:     next_rdata = {16'h0,
            active_val[pwm_clk_pkg::SH_SYNC]};
         pwm_clk_pkg::ADDR_STATUS:          next_rdata = {20'h0,
            sync_update_counter, 4'h0, pending};
         default:                           next_rmapped = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   sequence s_cfg_write_blocked;
      ce && write_fire && awaddr == pwm_clk_pkg::ADDR_CLK_CFG && !cfg_open;
   endsequence

   sequence s_sync_change;
      ce && update_event && pending[pwm_clk_pkg::SH_SYNC];
   endsequence

   a_cfg_protect: assert property (@(posedge aclk) disable iff (!aresetn)
      s_cfg_write_blocked |=> $stable(clk_cfg))
      else $error("protected clock configuration was written");

   a_update_cause: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && !(period_end && sync_reached)
      |=> $stable(active_val[pwm_clk_pkg::SH_DUTY]))
      else $error("duty applied outside an update event");

   a_sync_apply: assert property (@(posedge aclk) disable iff (!aresetn)
      s_sync_change |=> sync_update_period_value ==
         $past(shadow_val[pwm_clk_pkg::SH_SYNC][pwm_clk_pkg::SYNC_W-1:0]))
      else $error("new update period not applied at the update event");

   a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && write_fire |=> bvalid)
      else $error("write response missing");
endmodule
`default_nettype wire

// >>> core/unused_placeholder_removed.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// >>> verification/pwm_clock_and_sync_update_bench.sv
// Purpose: Self-checking bench for the PWM clock and sync update block
// Assumes: 125 MHz aclk, AXI4-Lite timing as handed over by the designer
// Notes:   Divided clocks are judged by the spacing of their ticks
`timescale 1ns/100ps
`default_nettype none
module pwm_clock_and_sync_update_bench;
   logic        aclk, aresetn, hard_prot;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rdat;
   logic [1:0]  bresp, rresp, rsp;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic        clk_a, clk_b, upd, pwm, ce;
   int          n_mismatch, num_checks, cycles, n;

   pwm_clock_sync u_dut (
      .aclk(aclk), .aresetn(aresetn), .ce(ce),
      .hard_protect_flag_g0(hard_prot),
      .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .divided_clock_a(clk_a), .divided_clock_b(clk_b),
      .update_pulse(upd), .pwm_out(pwm)
   );

   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end

   ////////////////////////////////////////////////////////////////////////
   task end_of_test;
      if (n_mismatch == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         n_mismatch++;
         end_of_test;
      end
   end

   task chk32(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task chk2(input logic [1:0] got, input logic [1:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: resp %b expected %b", $time, got, exp);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   task bus_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      @(posedge aclk);
      while (awready !== 1'b1) @(posedge aclk);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      @(posedge aclk);
      while (bvalid !== 1'b1) @(posedge aclk);
      rsp = bresp;
      bready <= 1'b0;
   endtask

   task bus_read(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      @(posedge aclk);
      while (arready !== 1'b1) @(posedge aclk);
      arvalid <= 1'b0;
      @(posedge aclk);
      while (rvalid !== 1'b1) @(posedge aclk);
      rdat = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask

   task wok(input logic [7:0] a, input logic [31:0] d);
      bus_write(a, d);
      chk2(rsp, pwm_clk_pkg::RESP_OKAY);
   endtask

   task rchk(input logic [7:0] a, input logic [31:0] exp);
      bus_read(a);
      chk2(rsp, pwm_clk_pkg::RESP_OKAY);
      chk32(rdat, exp);
   endtask

   function automatic logic pick(input int s);
      return (s == 0) ? clk_a : (s == 1) ? clk_b : upd;
   endfunction

   // Cycles until the chosen tick is seen, or the limit
   task wait_sig(input int s, input int lim);
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (pick(s) !== 1'b1 && n < lim);
   endtask

   ////////////////////////////////////////////////////////////////////////
   task test_protect;
      rchk(pwm_clk_pkg::ADDR_CLK_CFG, pwm_clk_pkg::CLK_CFG_RESET);
      wok(pwm_clk_pkg::ADDR_PROTECT, 32'h0000_0001);
      wok(pwm_clk_pkg::ADDR_CLK_CFG, 32'h0000_0012);
      rchk(pwm_clk_pkg::ADDR_CLK_CFG, 32'h0000_0000);
      wok(pwm_clk_pkg::ADDR_PROTECT, 32'h0000_0000);
      hard_prot <= 1'b1;
      wok(pwm_clk_pkg::ADDR_CLK_CFG, 32'h0000_0012);
      rchk(pwm_clk_pkg::ADDR_PROTECT, 32'h0000_0002);
      rchk(pwm_clk_pkg::ADDR_CLK_CFG, 32'h0000_0000);
      hard_prot <= 1'b0;
      wok(pwm_clk_pkg::ADDR_CLK_CFG, 32'hffff_ffff);
      rchk(pwm_clk_pkg::ADDR_CLK_CFG, pwm_clk_pkg::CLK_CFG_MASK);
      bus_read(8'h30);
      chk2(rsp, pwm_clk_pkg::RESP_SLVERR);
      chk32(rdat, 32'h0000_0000);
      bus_write(8'hfc, 32'h0000_0001);
      chk2(rsp, pwm_clk_pkg::RESP_SLVERR);
      wok(pwm_clk_pkg::ADDR_DUTY_ACTIVE, 32'h0000_0005);
      rchk(pwm_clk_pkg::ADDR_DUTY_ACTIVE, 32'h0000_0000);
   endtask

   task automatic test_clocks;
      logic [31:0] cfg[4] = '{32'h0a01_0001, 32'h0102_0203,
                              32'h0000_00ff, 32'h0b01_0500};
      int          ea[4] = '{1, 12, 255, 0};
      int          eb[4] = '{1024, 4, 0, 0};
      int          e;
      for (int i = 0; i < 4; i++) begin
         wok(pwm_clk_pkg::ADDR_CLK_CFG, cfg[i]);
         rchk(pwm_clk_pkg::ADDR_CLK_CFG, cfg[i]);
         for (int s = 0; s < 2; s++) begin
            e = (s == 1) ? eb[i] : ea[i];
            wait_sig(s, 2100);
            if (e == 0) begin
               chk32({31'h0, pick(s)}, 32'h0);
            end else begin
               wait_sig(s, 2100);
               chk32(32'(n), 32'(e));
            end
         end
      end
   endtask

   task test_update;
      int hi;
      wok(pwm_clk_pkg::ADDR_CLK_CFG, 32'h0000_0004);
      // Sync channels present, update method 1
      wok(pwm_clk_pkg::ADDR_SYNC_MODE, 32'h0000_0011);
      rchk(pwm_clk_pkg::ADDR_SYNC_MODE, 32'h0000_0011);
      wok(pwm_clk_pkg::ADDR_PERIOD_SHADOW, 32'h0000_0003);
      wok(pwm_clk_pkg::ADDR_SYNC_SHADOW, 32'h0000_0002);
      wait_sig(2, 1000);
      wait_sig(2, 1000);
      chk32(32'(n), 32'd48);
      rchk(pwm_clk_pkg::ADDR_PERIOD_ACTIVE, 32'h0000_0003);
      rchk(pwm_clk_pkg::ADDR_SYNC_ACTIVE, 32'h0000_0002);
      wait_sig(2, 1000);
      wok(pwm_clk_pkg::ADDR_DUTY_SHADOW, 32'h0000_0005);
      wok(pwm_clk_pkg::ADDR_DUTY_SHADOW, 32'h0000_0002);
      wok(pwm_clk_pkg::ADDR_SYNC_SHADOW, 32'h0000_0000);
      rchk(pwm_clk_pkg::ADDR_DUTY_ACTIVE, 32'h0000_0000);
      rchk(pwm_clk_pkg::ADDR_SYNC_ACTIVE, 32'h0000_0002);
      bus_read(pwm_clk_pkg::ADDR_STATUS);
      chk32(rdat & 32'h0000_000f, 32'h0000_0009);
      wait_sig(2, 1000);
      rchk(pwm_clk_pkg::ADDR_DUTY_ACTIVE, 32'h0000_0002);
      rchk(pwm_clk_pkg::ADDR_SYNC_ACTIVE, 32'h0000_0000);
      wait_sig(2, 1000);
      wait_sig(2, 1000);
      chk32(32'(n), 32'd16);
      hi = 0;
      repeat (48) begin
         @(posedge aclk);
         hi += (pwm === 1'b1);
      end
      chk32(32'(hi), 32'd24);
   endtask

   // Clock enable low must freeze the divided_clock_a output (clock B is not checked)
   task test_freeze;
      logic held;
      @(posedge aclk);
      ce <= 1'b0;
      @(posedge aclk);
      held = clk_a;
      repeat (20) begin
         @(posedge aclk);
         chk32({31'h0, clk_a}, {31'h0, held});
      end
      ce <= 1'b1;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      aresetn = 1'b0;
      hard_prot = 1'b0;
      ce = 1'b1;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0000_0000;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      n_mismatch = 0;
      num_checks = 0;
      cycles = 0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      test_protect;
      test_clocks;
      test_update;
      test_freeze;
      end_of_test;
   end
endmodule
`default_nettype wire
